// >>> hw/smr_pkg.sv
package smr_pkg;
    // ****************************************
    // Controller registers (byte addresses)
    // ****************************************
    localparam logic [3:0] REG_CMD = 4'h0;    // Command word
    localparam logic [3:0] REG_ADDR = 4'h4;   // Bank and row/column
    localparam logic [3:0] REG_STATUS = 4'h8; // Status and bank state
    localparam logic [3:0] REG_RDATA = 4'hc;  // Captured pattern word
    // Command field codes
    localparam logic [2:0] OP_ACT = 3'h1;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_PREA = 3'h3;
    localparam logic [2:0] OP_READ = 3'h4;
    localparam logic [2:0] OP_WRITE = 3'h5;
    localparam logic [2:0] OP_PAT_ON = 3'h6;
    localparam logic [2:0] OP_PAT_OFF = 3'h7;
    // Command and status word bit positions
    localparam int CMD_AP_BIT = 3;            // Auto precharge request
    localparam int CMD_BL8_BIT = 4;           // Full burst request
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PAT_BIT = 1;
    localparam int ST_ERR_BIT = 2;
    localparam int ST_OPEN_LSB = 8;
    // Device field layout
    localparam int BANKS = 8;
    localparam int ROW_W = 13;
    localparam logic [2:0] MR3_PAT_EN = 3'h4; // Enable, location 00b
    localparam logic [2:0] MR3_PAT_OFF = 3'h0;
    localparam logic [1:0] MR_SEL_THREE = 2'h3;
    localparam logic [7:0] PATTERN = 8'haa;   // Beats 0..7 = 0,1,0,1,...
    // Timing, in ns and derived cycles at 4 ns
    localparam int CLK_NS = 4;
    localparam int T_PRECHARGE_NS = 15;
    localparam int T_MODE_UPDATE_NS = 15;
    localparam int T_MODE_SET_CK = 4;
    localparam int T_PAT_RECOVERY_CK = 1;
    localparam int T_CCD_CK = 4;
    localparam int READ_LATENCY = 6;          // Additive plus column latency
    localparam int N_PRECHARGE = (T_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_MODE_UPD = (T_MODE_UPDATE_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_MODE = (N_MODE_UPD > T_MODE_SET_CK) ? N_MODE_UPD : T_MODE_SET_CK;
    // Controller states
    typedef enum logic [1:0] {SMR_IDLE, SMR_ISSUE, SMR_WAIT, SMR_CAPT} smr_state_t;
endpackage

// >>> hw/smr_capture.sv
`timescale 1ns/1ns
// ****************************************
// Pattern capture indexed bit register
// ****************************************
module smr_capture (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [2:0] first_beat,
    input wire logic [3:0] beats,
    // Device data, bit 0 of each lane
    input wire logic lane_lo_bit,
    input wire logic lane_hi_bit,
    // Result
    output logic [7:0] word,
    output logic lane_err,
    output logic done
);
    logic [3:0] left;   // Beats remaining
    logic [2:0] pos;    // Beat index
    // Store beats in, beat index picks bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            left <= 4'h0;
            pos <= 3'h0;
            word <= 8'h00;
            lane_err <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                left <= beats;
                pos <= first_beat;
                lane_err <= 1'b0;
            end else if (left != 4'h0) begin
                word[pos] <= lane_lo_bit;
                if (lane_lo_bit != lane_hi_bit) begin
                    lane_err <= 1'b1;
                end
                pos <= pos + 3'h1;
                left <= left - 4'h1;
                done <= (left == 4'h1);
            end
        end
    end
endmodule // smr_capture

// >>> hw/smr_ctrl.sv
`timescale 1ns/1ns
// ****************************************
// Memory command controller with pattern readout
// ****************************************
module smr_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device command pins
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [2:0] bank_select_inputs,
    output logic [12:0] mem_addr,
    // Device read data, bit 0 of each lane
    input wire logic lower_byte_data_lane_bit,
    input wire logic upper_byte_data_lane_bit
);
    // ****************************************
    // Declarations
    // ****************************************
    smr_pkg::smr_state_t state;             // Sequencer state
    logic [2:0] op;                         // Latched command code
    logic ap_req;                           // Auto precharge wanted
    logic bl8_req;                          // Full burst wanted
    logic [2:0] bank;                       // Latched bank
    logic [12:0] row_col;                   // Latched row or column
    logic [7:0] wait_cnt;                   // Spacing counter
    logic [7:0] lat_cnt;                    // Latency counter
    logic pattern_on;                       // Pattern readout enabled
    logic err;                              // Sticky illegal command or lane mismatch
    logic [7:0] bank_open;                  // Row open per bank
    logic [12:0] open_row [8];              // Open row per bank
    logic [7:0] pre_cnt [8];                // Precharge period per bank
    logic [7:0] rdata;                      // Last captured word

    // Capture handshake
    logic cap_start;
    logic [7:0] cap_word;
    logic cap_err;
    logic cap_done;

    // Bus decode
    logic wb_req;
    logic cmd_wr;
    logic legal;

    // Access strobe
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd_wr = wb_req && wb_we_i && wb_adr_i == smr_pkg::REG_CMD && wb_sel_i[0]
        && state == smr_pkg::SMR_IDLE;

    // Command legality check against mode and bank state
    function automatic logic cmd_legal(input logic [2:0] c, input logic [2:0] b, input logic pat);
        logic ok;
        ok = 1'b1;
        if (pat) begin
            ok = (c == smr_pkg::OP_READ) || (c == smr_pkg::OP_PAT_OFF);
            if (c == smr_pkg::OP_WRITE) begin
                ok = 1'b0;
            end
        end else begin
            unique case (c)
                smr_pkg::OP_ACT: ok = !bank_open[b] && pre_cnt[b] == 8'h00;
                smr_pkg::OP_READ, smr_pkg::OP_WRITE: ok = bank_open[b];
                default: ok = 1'b1;
            endcase
        end
        // Code zero names no command
        if (c == 3'h0) begin
            ok = 1'b0;
        end
        return ok;
    endfunction
    assign legal = cmd_legal(wb_dat_i[2:0], bank, pattern_on);

    // ****************************************
    // Wishbone answer
    // ****************************************
    // One-cycle ack and read mux
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    smr_pkg::REG_ADDR: wb_dat_o <= {16'h0000, bank, row_col};
                    smr_pkg::REG_STATUS: wb_dat_o <= {16'h0000, bank_open, 5'h00, err, pattern_on,
                        state != smr_pkg::SMR_IDLE};
                    smr_pkg::REG_RDATA: wb_dat_o <= {24'h000000, rdata};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Address register write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bank <= 3'h0;
            row_col <= 13'h0000;
        end else if (wb_req && wb_we_i && wb_adr_i == smr_pkg::REG_ADDR && state == smr_pkg::SMR_IDLE) begin
            if (wb_sel_i[0]) begin
                row_col[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                row_col[12:8] <= wb_dat_i[12:8];
                bank <= wb_dat_i[15:13];
            end
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    // Latch, issue, space and capture
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= smr_pkg::SMR_IDLE;
            op <= 3'h0;
            ap_req <= 1'b0;
            bl8_req <= 1'b0;
            wait_cnt <= 8'h00;
            lat_cnt <= 8'h00;
            pattern_on <= 1'b0;
            err <= 1'b0;
        end else begin
            // Write one clears error
            if (wb_req && wb_we_i && wb_adr_i == smr_pkg::REG_STATUS && wb_dat_i[smr_pkg::ST_ERR_BIT]) begin
                err <= 1'b0;
            end
            unique case (state)
                smr_pkg::SMR_IDLE: begin
                    if (cmd_wr) begin
                        if (legal) begin
                            op <= wb_dat_i[2:0];
                            ap_req <= wb_dat_i[smr_pkg::CMD_AP_BIT];
                            bl8_req <= wb_dat_i[smr_pkg::CMD_BL8_BIT];
                            state <= smr_pkg::SMR_ISSUE;
                        end else begin
                            // Refuse, flag error
                            err <= 1'b1;
                        end
                    end
                end
                smr_pkg::SMR_ISSUE: begin
                    state <= smr_pkg::SMR_WAIT;
                    unique case (op)
                        smr_pkg::OP_PREA, smr_pkg::OP_PRE: wait_cnt <= 8'(smr_pkg::N_PRECHARGE);
                        smr_pkg::OP_PAT_ON: begin
                            pattern_on <= 1'b1;
                            wait_cnt <= 8'(smr_pkg::N_MODE);
                        end
                        smr_pkg::OP_PAT_OFF: begin
                            pattern_on <= 1'b0;
                            wait_cnt <= 8'(smr_pkg::N_MODE);
                        end
                        smr_pkg::OP_READ: begin
                            lat_cnt <= 8'(smr_pkg::READ_LATENCY);
                            state <= smr_pkg::SMR_CAPT;
                        end
                        default: wait_cnt <= 8'(smr_pkg::T_CCD_CK);
                    endcase
                end
                smr_pkg::SMR_WAIT: begin
                    // Count spacing down
                    if (wait_cnt <= 8'h01) begin
                        state <= smr_pkg::SMR_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 8'h01;
                    end
                end
                smr_pkg::SMR_CAPT: begin
                    // Latency, then the burst
                    if (lat_cnt != 8'h00) begin
                        lat_cnt <= lat_cnt - 8'h01;
                    end else if (cap_done) begin
                        wait_cnt <= 8'(pattern_on ? smr_pkg::T_PAT_RECOVERY_CK : smr_pkg::T_CCD_CK);
                        state <= smr_pkg::SMR_WAIT;
                        if (cap_err) begin
                            err <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Capture starts one cycle before data
    assign cap_start = state == smr_pkg::SMR_CAPT && lat_cnt == 8'h01;

    // Keep last captured word
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (cap_done) begin
            // software reruns reads on this word
            rdata <= cap_word;
        end
    end

    // ****************************************
    // Bank tracking
    // ****************************************
    // Open rows and precharge timers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bank_open <= 8'h00;
            for (int i = 0; i < smr_pkg::BANKS; i++) begin
                open_row[i] <= 13'h0000;
                pre_cnt[i] <= 8'h00;
            end
        end else begin
            // Precharge timers tick down
            for (int i = 0; i < smr_pkg::BANKS; i++) begin
                if (pre_cnt[i] != 8'h00) begin
                    pre_cnt[i] <= pre_cnt[i] - 8'h01;
                end
            end
            if (state == smr_pkg::SMR_ISSUE) begin
                unique case (op)
                    smr_pkg::OP_ACT: begin
                        bank_open[bank] <= 1'b1;
                        open_row[bank] <= row_col;
                    end
                    smr_pkg::OP_PRE: begin
                        bank_open[bank] <= 1'b0;
                        pre_cnt[bank] <= 8'(smr_pkg::N_PRECHARGE);
                    end
                    smr_pkg::OP_PREA: begin
                        bank_open <= 8'h00;
                        for (int i = 0; i < smr_pkg::BANKS; i++) begin
                            pre_cnt[i] <= 8'(smr_pkg::N_PRECHARGE);
                        end
                    end
                    smr_pkg::OP_READ, smr_pkg::OP_WRITE: begin
                        // auto precharge closes only this bank
                        if (ap_req && !pattern_on) begin
                            bank_open[bank] <= 1'b0;
                            pre_cnt[bank] <= 8'(smr_pkg::N_PRECHARGE + smr_pkg::T_CCD_CK);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Registered command, address and bank pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'hf;
            bank_select_inputs <= 3'h0;
            mem_addr <= 13'h0000;
        end else begin
            // Idle pins show a no-op
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'h7;
            if (state == smr_pkg::SMR_ISSUE) begin
                bank_select_inputs <= bank;
                mem_addr <= row_col;
                unique case (op)
                    // Activate
                    smr_pkg::OP_ACT: {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'h3;
                    // Precharge one or all
                    smr_pkg::OP_PRE, smr_pkg::OP_PREA: begin
                        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'h2;
                        mem_addr[10] <= (op == smr_pkg::OP_PREA);
                    end
                    // Column access
                    smr_pkg::OP_READ, smr_pkg::OP_WRITE: begin
                        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= (op == smr_pkg::OP_READ) ? 4'h5 : 4'h4;
                        // bit 12 not a column bit
                        mem_addr[12] <= bl8_req;
                        mem_addr[10] <= ap_req;
                        if (pattern_on) begin
                            mem_addr[1:0] <= 2'h0;
                            mem_addr[2] <= bl8_req ? 1'b0 : row_col[2];
                        end
                    end
                    // Mode set
                    default: begin
                        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'h0;
                        bank_select_inputs <= {1'b0, smr_pkg::MR_SEL_THREE};
                        mem_addr <= {10'h000, (op == smr_pkg::OP_PAT_ON) ? smr_pkg::MR3_PAT_EN : smr_pkg::MR3_PAT_OFF};
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Capture
    // ****************************************
    // eight beats at base 0
    // four beats at base 0 or 4
    smr_capture u_capture (
        .clock(clock),
        .rst_n(rst_n),
        .start(cap_start),
        .first_beat(bl8_req ? 3'h0 : {row_col[2], 2'h0}),
        .beats(bl8_req ? 4'h8 : 4'h4),
        .lane_lo_bit(lower_byte_data_lane_bit),
        .lane_hi_bit(upper_byte_data_lane_bit),
        .word(cap_word),
        .lane_err(cap_err),
        .done(cap_done)
    );

    // device side, reads here go to array once disabled
endmodule // smr_ctrl

// >>> tb/smr_ctrl_properties.sv
`timescale 1ns/1ns
// ****************************************
// Controller bus and command pin checks
// ****************************************
module smr_ctrl_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Command pins
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [2:0] bank_select_inputs,
    input wire logic [12:0] mem_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Command decode, NOP excluded
    wire [2:0] c = {mem_ras_n, mem_cas_n, mem_we_n};
    wire cmd = !mem_cs_n && c != 3'h7;
    wire act = cmd && c == 3'h3;
    wire pre = cmd && c == 3'h2;
    wire rd = cmd && c == 3'h5;
    wire wr = cmd && c == 3'h4;
    wire mrs = cmd && c == 3'h0;
    wire [2:0] ba = bank_select_inputs;
    logic pat; // Pattern mode seen on pins
    logic [7:0] open; // Banks with a row open
    logic [3:0] since; // Cycles since last precharge
    // Pattern mode tracking
    always_ff @(posedge clock) begin
        if (!rst_n) pat <= 1'h0;
        else if (mrs && ba == 3'h3) pat <= mem_addr[2];
    end
    // Open bank tracking, auto precharge closes
    always_ff @(posedge clock) begin
        if (!rst_n) open <= 8'h0;
        else if (act) open[ba] <= 1'h1;
        else if (pre && mem_addr[10]) open <= 8'h0;
        else if (pre || ((rd || wr) && !pat && mem_addr[10])) open[ba] <= 1'h0;
    end
    // Saturating precharge age
    always_ff @(posedge clock) begin
        if (!rst_n) since <= 4'hf;
        else if (pre) since <= 4'h1;
        else if (since != 4'hf) since <= since + 4'h1;
    end
    ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    reset_nop_a: assert property ($rose(rst_n) |-> {mem_cs_n, c} == 4'hf ##1 {mem_cs_n, c} == 4'h7)
        else $error("pins not idle around reset release");
    pat_no_write_a: assert property (pat |-> !wr)
        else $error("write during pattern mode");
    pat_reads_only_a: assert property (pat && cmd |-> rd || mrs)
        else $error("non-read command in pattern mode");
    pat_read_addr_a: assert property (pat && rd |-> mem_addr[1:0] == 2'h0 && !(mem_addr[12] && mem_addr[2]))
        else $error("bad pattern read address");
    pat_entry_a: assert property (mrs && ba == 3'h3 && mem_addr[2] |->
        mem_addr[1:0] == 2'h0 && open == 8'h0 && since >= smr_pkg::N_PRECHARGE)
        else $error("pattern entry without idle banks");
    mode_wait_a: assert property (mrs |=> !cmd [*3])
        else $error("command too soon after mode set");
    read_spacing_a: assert property (rd |=> !rd [*3])
        else $error("reads closer than four cycles");
    act_closed_a: assert property (act |-> !open[ba])
        else $error("activate to open bank");
    access_open_a: assert property ((rd || wr) && !pat |-> open[ba])
        else $error("access to idle bank");
    cover property (rd && pat && mem_addr[12]);
    cover property (rd && pat && !mem_addr[12] && mem_addr[2]);
    cover property (mrs && ba == 3'h3 && mem_addr[2]);
endmodule // smr_ctrl_properties

// >>> tb/smr_mem_model.sv
`timescale 1ns/1ns
// ****************************************
// Behavioural memory device
// ****************************************
module smr_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Command pins
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [2:0] bank_select_inputs,
    input wire logic [12:0] mem_addr,
    // Read data, bit 0 of each lane
    output logic lower_byte_data_lane_bit,
    output logic upper_byte_data_lane_bit,
    // Command breaches seen
    output logic [7:0] n_viol
);
    wire [2:0] c = {mem_ras_n, mem_cas_n, mem_we_n};
    wire [2:0] ba = bank_select_inputs;
    wire [12:0] a = mem_addr;
    logic pat; // Pattern mode
    logic [7:0] open; // Open banks
    logic [7:0] w; // Beats left, beat 0 in bit 0
    logic q = 1'h0; // Lane level
    logic bad; // Breach this edge
    int t = 0, t_mrs, t_end, dly = 0, nb = 0;
    int tp [8];
    assign lower_byte_data_lane_bit = q;
    assign upper_byte_data_lane_bit = q;
    // Command decode, state and breach watch
    always @(posedge clock) begin
        t <= t + 1;
        bad = 1'h0;
        if (!rst_n) begin
            pat <= 1'h0;
            open <= 8'h0;
            n_viol <= 8'h0;
            nb <= 0;
            t_mrs <= -99;
            t_end <= -99;
            for (int i = 0; i < 8; i++) tp[i] <= -99;
        end else if (!mem_cs_n) begin
            case (c)
                3'h3: begin
                    bad = open[ba] || pat || t - tp[ba] < smr_pkg::N_PRECHARGE || t - t_mrs < smr_pkg::N_MODE;
                    open[ba] <= 1'h1;
                end
                3'h2: begin
                    bad = pat;
                    for (int i = 0; i < 8; i++) if (a[10] || i == ba) open[i] <= 1'h0;
                    for (int i = 0; i < 8; i++) if (a[10] || i == ba) tp[i] <= t;
                end
                3'h5: begin
                    bad = pat ? (a[1:0] != 2'h0 || (a[12] && a[2])) : !open[ba];
                    bad = bad || t - t_mrs < smr_pkg::N_MODE;
                    w <= pat ? (a[2] ? 8'h0a : 8'haa) : a[7:0] ^ 8'h33;
                    nb <= a[12] ? 8 : 4;
                    dly <= smr_pkg::READ_LATENCY - 2;
                    t_end <= t + smr_pkg::READ_LATENCY + (a[12] ? 7 : 3);
                    if (!pat && a[10]) open[ba] <= 1'h0;
                end
                3'h4: bad = pat || !open[ba];
                3'h0: begin
                    if (ba == 3'h3 && a[2]) bad = a[1:0] != 2'h0 || open != 8'h0;
                    else if (ba == 3'h3) bad = t - t_end < smr_pkg::T_PAT_RECOVERY_CK;
                    else bad = pat;
                    for (int i = 0; i < 8; i++) if (a[2] && t - tp[i] < smr_pkg::N_PRECHARGE) bad = 1'h1;
                    if (ba == 3'h3) pat <= a[2];
                    t_mrs <= t;
                end
                default: bad = 1'h0;
            endcase
            if (bad) n_viol <= n_viol + 8'h1;
        end
    end
    // Beats from read latency, released lane toggles
    always @(posedge clock) begin
        if (nb != 0 && dly != 0) dly <= dly - 1;
        else if (nb != 0) begin
            q <= w[0];
            w <= w >> 1;
            nb <= nb - 1;
        end else q <= !q;
    end
endmodule // smr_mem_model

// >>> tb/smr_ctrl_test.sv
`timescale 1ns/1ns
// ****************************************
// Controller self-checking bench
// ****************************************
module smr_ctrl_test;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_v, r;
    logic wb_ack_o, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
    logic lower_byte_data_lane_bit, upper_byte_data_lane_bit;
    logic [2:0] bank_select_inputs, b;
    logic [12:0] mem_addr;
    logic [7:0] n_viol;
    logic [7:0] em [3] = '{8'hff, 8'h0f, 8'hf0}; // Captured bits per read kind
    logic [31:0] q_val [$], q_msk [$]; // Expected reads
    int n_fail = 0, comparisons = 0, m;
    smr_ctrl u_dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .bank_select_inputs,
        .mem_addr, .lower_byte_data_lane_bit, .upper_byte_data_lane_bit);
    smr_mem_model u_mem (.clock, .rst_n, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n,
        .bank_select_inputs, .mem_addr, .lower_byte_data_lane_bit, .upper_byte_data_lane_bit, .n_viol);
    // Free running clock
    always #2 clock = ~clock;
    // Masked compare of one result
    task automatic chk(input logic [31:0] e, input logic [31:0] k, input logic [31:0] g);
        comparisons++;
        if ((g & k) !== (e & k)) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g & k, e & k);
        end
    endtask
    // Print counts and end the run
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Wait ran out
    task automatic stuck;
        n_fail++;
        give_verdict();
    endtask
    // One classic bus cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] o);
        int k;
        @(posedge clock);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 20);
        o = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (k >= 20) stuck();
    endtask
    // Read with a noted expectation
    task automatic expect_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] k);
        q_val.push_back(e);
        q_msk.push_back(k);
        wb(1'h0, a, 32'h0, rd_v);
    endtask
    // Poll status until not busy
    task automatic idle;
        int k;
        for (k = 0; k < 40; k++) begin
            wb(1'h0, smr_pkg::REG_STATUS, 32'h0, rd_v);
            if (rd_v[smr_pkg::ST_BUSY_BIT] === 1'h0) break;
        end
        if (k == 40) stuck();
    endtask
    // Load address, issue a command, wait
    task automatic cmd(input logic [15:0] ad, input logic [4:0] op);
        wb(1'h1, smr_pkg::REG_ADDR, {16'h0, ad}, rd_v);
        wb(1'h1, smr_pkg::REG_CMD, {27'h0, op}, rd_v);
        idle();
    endtask
    // Result watcher pops the oldest note mid-cycle
    always @(negedge clock) begin
        if (wb_ack_o === 1'h1 && !wb_we_i && q_val.size() > 0) chk(q_val.pop_front(), q_msk.pop_front(), wb_dat_o);
    end
    // Main sequence
    initial begin
        r = $urandom(32'hce43);
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        expect_rd(smr_pkg::REG_STATUS, 32'h0, 32'hff07);
        b = $urandom_range(7);
        r = $urandom;
        cmd({b, r[12:0]}, {2'h0, smr_pkg::OP_ACT});
        expect_rd(smr_pkg::REG_STATUS, 32'h100 << b, 32'hff07);
        cmd({b, 13'h8}, {2'h2, smr_pkg::OP_READ});
        cmd(16'h0, {2'h0, smr_pkg::OP_PREA});
        expect_rd(smr_pkg::REG_STATUS, 32'h0, 32'hff07);
        cmd(16'h0, {2'h0, smr_pkg::OP_PAT_ON});
        expect_rd(smr_pkg::REG_STATUS, 32'h2, 32'h7);
        for (int i = 0; i < 12; i++) begin
            m = i % 3;
            r = $urandom;
            cmd({r[15:13], 4'h0, r[9:4], m == 2, 2'h0}, {m == 0, r[0], smr_pkg::OP_READ});
            expect_rd(smr_pkg::REG_RDATA, {24'h0, 8'haa & em[m]}, {24'h0, em[m]});
        end
        cmd(16'h0, {2'h0, smr_pkg::OP_WRITE});
        expect_rd(smr_pkg::REG_STATUS, 32'h6, 32'h7);
        wb(1'h1, smr_pkg::REG_STATUS, 32'h4, rd_v);
        expect_rd(smr_pkg::REG_STATUS, 32'h2, 32'h7);
        cmd(16'h0, {2'h0, smr_pkg::OP_PAT_OFF});
        expect_rd(smr_pkg::REG_STATUS, 32'h0, 32'h7);
        cmd({b, 13'h5}, {2'h0, smr_pkg::OP_ACT});
        cmd({b, 13'h0}, {2'h0, smr_pkg::OP_READ});
        expect_rd(smr_pkg::REG_RDATA, 32'h3, 32'hf);
        expect_rd(smr_pkg::REG_STATUS, 32'h100 << b, 32'hff07);
        cmd({b, 13'h0}, {2'h0, smr_pkg::OP_PRE});
        cmd({b, 13'h0}, {2'h0, smr_pkg::OP_PRE});
        expect_rd(smr_pkg::REG_STATUS, 32'h0, 32'hff07);
        chk(32'h0, 32'hff, {24'h0, n_viol});
        give_verdict();
    end
endmodule // smr_ctrl_test
bind smr_ctrl smr_ctrl_properties u_props (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .bank_select_inputs, .mem_addr);
